// file: ipws_cfg.svh
// register map, field positions, reset values and counts of the interrupt selector
`ifndef IPWS_CFG_SVH
`define IPWS_CFG_SVH

// ==========================================================
// register offsets (byte addresses within the block)
`define IPWS_OFF_SET_ENABLE   12'h100
`define IPWS_OFF_CLR_ENABLE   12'h180
`define IPWS_OFF_SET_PENDING  12'h200
`define IPWS_OFF_CLR_PENDING  12'h280
`define IPWS_OFF_ACTIVE       12'h300
`define IPWS_OFF_PRIO_BASE    12'h400
`define IPWS_OFF_PRIO_LAST    12'h40c
`define IPWS_OFF_WAKE_STATUS  12'h500
`define IPWS_OFF_SEL_STATUS   12'h504

// ==========================================================
// field layout and reset values
`define IPWS_NUM_SRC          14
`define IPWS_PRIO_LSB         5
`define IPWS_LANE_W           8
`define IPWS_PRIO_RESET       3'h0
`define IPWS_WAKE_MASK        14'h040f
`define IPWS_ADDR_W           12

`endif

// file: ipws_pkg.sv
// types shared by the interrupt priority and wake selector
package ipws_pkg;

	typedef logic [2:0] ipws_prio_t;
	typedef logic [3:0] ipws_idx_t;

	typedef enum logic [2:0] {
		IPWS_ACTIVE    = 3'b001,
		IPWS_SLEEPING  = 3'b010,
		IPWS_HIBERNATE = 3'b100
	} ipws_power_e;

endpackage : ipws_pkg

// file: ipws_top.sv
// interrupt enable, pending, priority arbitration and hibernate wake selection
// ==========================================================
// Summary of operation
// R1: fourteen request inputs at fixed positions 0 to 13.
// R2: only positions 0, 1, 2, 3 and 10 wake the core from hibernate.
// R3: any wake event returns the power state to active.
// R4: each source has a 3-bit priority, 0 most urgent, 7 least.
// R5: programmable level 0 still ranks below reset, nmi and hard fault.
// R6: all priority fields reset to level zero.
// R7: equal levels resolve to the lower position number.
// R8: set-enable and clear-enable writes change each source's enable state.
// R9: priority registers one to three hold four sources, register four two; one 8-bit lane each.
// R10: first register fields at 7:5, 15:13, 23:21, 31:29; rest reserved.
// R11: field code 000 is most urgent, 111 least urgent.
// R12: registers two to four repeat the lane layout for positions 4 to 13.
// R13: software sets the watchdog to reset the device, not rely on interrupt.
// R14: enable and pending set/clear registers act only on bits written one.
// R15: disabled sources still pend but are never selected.
// R16: every cycle the arbiter presents the best enabled pending source; the code presents none while nmi or hard fault is raised.
`include "ipws_cfg.svh"

module ipws_top #(
	parameter int NUM_SRC = `IPWS_NUM_SRC
) (
	// clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// apb slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [`IPWS_ADDR_W-1:0] paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// peripheral request lines
	input  wire logic [NUM_SRC-1:0]      irq_req,
	// core side: higher-ranked exceptions
	input  wire logic                    nmi_req,
	input  wire logic                    hard_fault_req,
	// core side: power state and exception return
	input  wire logic                    sleep_enter,
	input  wire logic                    hibernate_enter,
	input  wire logic                    irq_ack,
	input  wire logic                    exc_return,
	// core side: selection outputs
	output logic                         irq_valid,
	output ipws_pkg::ipws_idx_t          irq_id,
	output ipws_pkg::ipws_prio_t         irq_level,
	output logic                         sys_exc_valid,
	output logic                         wake_event,
	output logic                         core_active
);

	localparam logic [NUM_SRC-1:0] WAKE_MASK = NUM_SRC'(`IPWS_WAKE_MASK);

	// ==========================================================
	// input synchronisers: three stages, change accepted when last two agree
	logic [NUM_SRC-1:0] req_s1_q;
	logic [NUM_SRC-1:0] req_s2_q;
	logic [NUM_SRC-1:0] req_s3_q;
	logic [NUM_SRC-1:0] req_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_s1_q <= '0;
			req_s2_q <= '0;
			req_s3_q <= '0;
		end else begin
			req_s1_q <= irq_req;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
		end
	end

	// filtered level: update bitwise only where stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_q <= '0;
		end else begin
			req_q <= (req_q & (req_s2_q ^ req_s3_q)) |
				(req_s3_q & ~(req_s2_q ^ req_s3_q)); // R1
		end
	end

	logic [NUM_SRC-1:0] req_d1_q;
	logic [NUM_SRC-1:0] req_rise;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_d1_q <= '0;
		end else begin
			req_d1_q <= req_q;
		end
	end

	assign req_rise = req_q & ~req_d1_q;

	// ==========================================================
	// apb decode
	logic wr_en;
	logic rd_setup;
	logic addr_ok;

	// writes to unmapped or unaligned addresses are dropped
	assign pready   = 1'b1;
	assign wr_en    = psel & penable & pwrite & addr_ok;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pslverr  = psel & penable & ~addr_ok;

	always_comb begin
		addr_ok = 1'b0;
		case (paddr)
			`IPWS_OFF_SET_ENABLE, `IPWS_OFF_CLR_ENABLE,
			`IPWS_OFF_SET_PENDING, `IPWS_OFF_CLR_PENDING,
			`IPWS_OFF_ACTIVE, `IPWS_OFF_WAKE_STATUS,
			`IPWS_OFF_SEL_STATUS: addr_ok = 1'b1;
			default: addr_ok = (paddr >= `IPWS_OFF_PRIO_BASE) &&
				(paddr <= `IPWS_OFF_PRIO_LAST) && (paddr[1:0] == 2'b00);
		endcase
	end

	logic [NUM_SRC-1:0] wdat;
	assign wdat = pwdata[NUM_SRC-1:0];

	// ==========================================================
	// enable state
	logic [NUM_SRC-1:0] enable_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_q <= '0;
		end else if (wr_en && paddr == `IPWS_OFF_SET_ENABLE) begin
			enable_q <= enable_q | wdat; // R8 R14
		end else if (wr_en && paddr == `IPWS_OFF_CLR_ENABLE) begin
			enable_q <= enable_q & ~wdat; // R8 R14
		end
	end

	// ==========================================================
	// pending and active state
	logic [NUM_SRC-1:0] pending_q;
	logic [NUM_SRC-1:0] active_q;
	logic [NUM_SRC-1:0] sw_set_pend;
	logic [NUM_SRC-1:0] sw_clr_pend;
	logic [NUM_SRC-1:0] take_oh;

	assign sw_set_pend = (wr_en && paddr == `IPWS_OFF_SET_PENDING) ? wdat : '0;
	assign sw_clr_pend = (wr_en && paddr == `IPWS_OFF_CLR_PENDING) ? wdat : '0;

	// a request arriving with a clear keeps its pending bit (set wins)
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending_q <= '0;
		end else begin
			pending_q <= ((pending_q & ~sw_clr_pend & ~take_oh) | req_rise | sw_set_pend); // R14 R15
		end
	end

	// active bits persist across disable until exception return; a take in that cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_q <= '0;
		end else if (exc_return) begin
			active_q <= take_oh;
		end else begin
			active_q <= active_q | take_oh;
		end
	end

	// ==========================================================
	// priority registers, one 3-bit field per 8-bit lane
	ipws_pkg::ipws_prio_t prio_q [NUM_SRC];
	logic [1:0]           prio_reg;
	assign prio_reg = paddr[3:2];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_SRC; i++) begin
				prio_q[i] <= `IPWS_PRIO_RESET; // R6
			end
		end else if (wr_en && paddr >= `IPWS_OFF_PRIO_BASE && paddr <= `IPWS_OFF_PRIO_LAST) begin
			for (int i = 0; i < NUM_SRC; i++) begin
				if (i / 4 == int'(prio_reg)) begin
					prio_q[i] <= pwdata[(i % 4) * `IPWS_LANE_W + `IPWS_PRIO_LSB +: 3]; // R9 R10 R12
				end
			end
		end
	end

	// ==========================================================
	// arbiter: lowest code wins, then lowest position
	logic                 cand_valid;
	ipws_pkg::ipws_idx_t  cand_id;
	ipws_pkg::ipws_prio_t cand_lvl;
	logic [NUM_SRC-1:0]   eligible;

	assign eligible = pending_q & enable_q; // R15

	always_comb begin
		cand_valid = 1'b0;
		cand_id    = '0;
		cand_lvl   = 3'h7;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (eligible[i] && (!cand_valid || prio_q[i] < cand_lvl)) begin // R4 R7 R11
				cand_valid = 1'b1;
				cand_id    = ipws_pkg::ipws_idx_t'(i);
				cand_lvl   = prio_q[i];
			end
		end
	end

	// nmi and hard fault mask every programmable level
	logic sys_exc;
	assign sys_exc = nmi_req | hard_fault_req; // R5

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_valid     <= 1'b0;
			irq_id        <= '0;
			irq_level     <= '0;
			sys_exc_valid <= 1'b0;
		end else begin
			irq_valid     <= cand_valid & ~sys_exc; // R5 R16
			irq_id        <= cand_id; // R16
			irq_level     <= cand_lvl;
			sys_exc_valid <= sys_exc;
		end
	end

	// acceptance moves the presented source from pending to active
	always_comb begin
		take_oh = '0;
		if (irq_ack && irq_valid) begin
			take_oh[irq_id] = 1'b1;
		end
	end

	// ==========================================================
	// power state and wake selection
	ipws_pkg::ipws_power_e pwr_q;
	logic                  wake_any;

	always_comb begin
		case (pwr_q)
			ipws_pkg::IPWS_HIBERNATE: wake_any = |(req_rise & WAKE_MASK); // R2
			ipws_pkg::IPWS_SLEEPING:  wake_any = |(req_rise & enable_q);
			default:                  wake_any = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_q <= ipws_pkg::IPWS_ACTIVE;
		end else begin
			case (pwr_q)
				ipws_pkg::IPWS_ACTIVE: begin
					if (hibernate_enter) begin
						pwr_q <= ipws_pkg::IPWS_HIBERNATE;
					end else if (sleep_enter) begin
						pwr_q <= ipws_pkg::IPWS_SLEEPING;
					end
				end
				ipws_pkg::IPWS_SLEEPING, ipws_pkg::IPWS_HIBERNATE: begin
					if (wake_any || sys_exc) begin
						pwr_q <= ipws_pkg::IPWS_ACTIVE; // R3
					end
				end
				default: pwr_q <= ipws_pkg::IPWS_ACTIVE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_event <= 1'b0;
		end else begin
			wake_event <= (pwr_q != ipws_pkg::IPWS_ACTIVE) && (wake_any || sys_exc);
		end
	end

	assign core_active = (pwr_q == ipws_pkg::IPWS_ACTIVE);

	// ==========================================================
	// read data, captured at the end of the setup phase
	logic [31:0] rd_d;
	logic [31:0] prio_word;

	always_comb begin
		prio_word = '0;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (i / 4 == int'(prio_reg)) begin
				prio_word[(i % 4) * `IPWS_LANE_W + `IPWS_PRIO_LSB +: 3] = prio_q[i]; // R10
			end
		end
	end

	always_comb begin
		rd_d = '0;
		case (paddr)
			`IPWS_OFF_SET_ENABLE, `IPWS_OFF_CLR_ENABLE: rd_d[NUM_SRC-1:0] = enable_q;
			`IPWS_OFF_SET_PENDING, `IPWS_OFF_CLR_PENDING: rd_d[NUM_SRC-1:0] = pending_q;
			`IPWS_OFF_ACTIVE:      rd_d[NUM_SRC-1:0] = active_q;
			`IPWS_OFF_WAKE_STATUS: rd_d = {29'h0, pwr_q};
			`IPWS_OFF_SEL_STATUS:  rd_d = {20'h0, cand_valid, cand_lvl, 4'h0, cand_id};
			default:               rd_d = addr_ok ? prio_word : 32'h0;
		endcase
	end

	// zero-wait read from a flop: returns state as of the setup edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else begin
			prdata <= rd_setup ? rd_d : 32'h0;
		end
	end

	// ==========================================================
	// checks
	hib_wake_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
		(pwr_q == ipws_pkg::IPWS_HIBERNATE && !sys_exc && (req_rise & WAKE_MASK) == '0)
			|=> (pwr_q == ipws_pkg::IPWS_HIBERNATE))
		else $error("hibernate left without a wake source");

	wake_active_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
		(pwr_q != ipws_pkg::IPWS_ACTIVE && wake_any) |=> core_active)
		else $error("wake did not return to active");

	disabled_never_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
		irq_valid |-> ((($past(enable_q) >> irq_id) & NUM_SRC'(1)) != '0))
		else $error("disabled source presented");

	sys_mask_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
		sys_exc |=> (!irq_valid && sys_exc_valid))
		else $error("programmable irq not masked by nmi or fault");

	best_level_a: assert property (@(posedge pclk) disable iff (!presetn) // R4
		cand_valid |-> (eligible[cand_id] && prio_q[cand_id] == cand_lvl))
		else $error("arbiter picked an ineligible source");

	logic [NUM_SRC-1:0] beats_cand;
	always_comb begin
		for (int i = 0; i < NUM_SRC; i++) begin
			beats_cand[i] = eligible[i] && (prio_q[i] < cand_lvl ||
				(prio_q[i] == cand_lvl && i < int'(cand_id)));
		end
	end
	best_rank_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
		cand_valid |-> (beats_cand == '0))
		else $error("a more urgent source was passed over");

	set_en_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
		(wr_en && paddr == `IPWS_OFF_SET_ENABLE) |=> ((enable_q & $past(wdat)) == $past(wdat)))
		else $error("set-enable did not enable");

	zero_write_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
		(wr_en && paddr == `IPWS_OFF_CLR_ENABLE) |=> ((enable_q & ~$past(wdat)) == ($past(enable_q) & ~$past(wdat))))
		else $error("clear-enable touched a bit written zero");

	pend_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
		(req_rise != '0) |=> ((pending_q & $past(req_rise)) == $past(req_rise)))
		else $error("request did not pend");

	present_a: assert property (@(posedge pclk) disable iff (!presetn) // R16
		(cand_valid && !sys_exc) |=> (irq_valid && irq_id == $past(cand_id)))
		else $error("arbiter result not presented");

endmodule : ipws_top

// file: ipws_core_model.sv
// core-side partner: takes the presented interrupt, then returns from it
module ipws_core_model (
	// clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// selection from the controller
	input  wire logic                irq_valid,
	input  wire ipws_pkg::ipws_idx_t irq_id,
	// bench control and observation
	input  wire logic                ack_en,
	output ipws_pkg::ipws_idx_t      taken_id,
	// exception handshake
	output logic                     irq_ack,
	output logic                     exc_return
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [2:0] hold_q;

	// ==========================================================
	// handler model
	// the hold keeps a second ack off while the selection is still settling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ack    <= 1'b0;
			exc_return <= 1'b0;
			taken_id   <= 4'h0;
			hold_q     <= 3'h0;
		end else begin
			irq_ack    <= 1'b0;
			exc_return <= 1'b0;
			if (hold_q != 3'h0) begin
				hold_q     <= hold_q - 3'h1;
				exc_return <= (hold_q == 3'h1);
			end else if (ack_en && irq_valid) begin
				irq_ack  <= 1'b1;
				taken_id <= irq_id;
				hold_q   <= 3'h6;
			end
		end
	end

endmodule : ipws_core_model

// file: ipws_tb.sv
// self-checking bench of the interrupt priority and wake selector
`include "ipws_cfg.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, irq_valid, sys_exc_valid, wake_event, core_active;
	logic [13:0] irq_req = 14'h0;
	logic        nmi_req = 1'b0, hard_fault_req = 1'b0, sleep_enter = 1'b0;
	logic        hibernate_enter = 1'b0, ack_en = 1'b0, irq_ack, exc_return;
	ipws_pkg::ipws_idx_t  irq_id, taken_id;
	ipws_pkg::ipws_prio_t irq_level;
	int          miscompares = 0, cmp_count = 0, tick = 0, wake_seen = 0;
	localparam logic [13:0] WAKE_SET = 14'h040f;

	ipws_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq_req(irq_req), .nmi_req(nmi_req),
		.hard_fault_req(hard_fault_req), .sleep_enter(sleep_enter),
		.hibernate_enter(hibernate_enter), .irq_ack(irq_ack), .exc_return(exc_return),
		.irq_valid(irq_valid), .irq_id(irq_id), .irq_level(irq_level),
		.sys_exc_valid(sys_exc_valid), .wake_event(wake_event), .core_active(core_active));

	ipws_core_model core (.pclk(pclk), .presetn(presetn), .irq_valid(irq_valid),
		.irq_id(irq_id), .ack_en(ack_en), .taken_id(taken_id), .irq_ack(irq_ack),
		.exc_return(exc_return));

	always #2 pclk = ~pclk;

	// ==========================================================
	// checking and closing
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// run far past the expected length, so only a hang ends here
	always @(posedge pclk) begin
		tick++;
		if (wake_event === 1'b1)
			wake_seen++;
		if (tick == 8000) begin
			miscompares++;
			report_and_stop();
		end
	end

	// ==========================================================
	// apb master
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask : wr

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, x);
	endtask : rd_chk

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	// ==========================================================
	// test sequence
	initial begin
		logic [31:0] q;
		logic        e;
		cyc(8);
		presetn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rd_chk(12'(`IPWS_OFF_PRIO_BASE + 4 * i), 32'h0);
			wr(12'(`IPWS_OFF_PRIO_BASE + 4 * i), 32'hffff_ffff);
			rd_chk(12'(`IPWS_OFF_PRIO_BASE + 4 * i), i == 3 ? 32'h0000_e0e0 : 32'he0e0_e0e0);
			wr(12'(`IPWS_OFF_PRIO_BASE + 4 * i), 32'h0);
		end
		apb(1'b0, 12'h600, 32'h0, q, e);
		chk(q, 32'h0);
		chk(32'(e), 32'h1);
		wr(`IPWS_OFF_SET_ENABLE, 32'h3fff);
		wr(`IPWS_OFF_CLR_ENABLE, 32'h0020);
		rd_chk(`IPWS_OFF_SET_ENABLE, 32'h3fdf);
		irq_req[5] <= 1'b1;
		cyc(8);
		rd_chk(`IPWS_OFF_SET_PENDING, 32'h0020);
		chk(32'(irq_valid), 32'h0);
		irq_req[5] <= 1'b0;
		wr(`IPWS_OFF_CLR_PENDING, 32'h3fff);
		wr(`IPWS_OFF_SET_ENABLE, 32'h0020);
		// equal level on 5 and 7: lower position wins
		wr(`IPWS_OFF_SET_PENDING, 32'h00a0);
		cyc(3);
		chk(32'(irq_id), 32'h5);
		chk(32'(irq_level), 32'h0);
		chk(32'(irq_valid), 32'h1);
		rd_chk(`IPWS_OFF_SEL_STATUS, 32'h0000_0805);
		wr(12'(`IPWS_OFF_PRIO_BASE + 4), 32'h2000_e000);
		cyc(3);
		chk(32'(irq_id), 32'h7);
		chk(32'(irq_level), 32'h1);
		nmi_req <= 1'b1;
		cyc(3);
		chk(32'(irq_valid), 32'h0);
		chk(32'(sys_exc_valid), 32'h1);
		nmi_req <= 1'b0;
		wr(`IPWS_OFF_CLR_PENDING, 32'h3fff);
		wr(12'(`IPWS_OFF_PRIO_BASE + 4), 32'h0);
		for (int i = 0; i < 14; i++) begin
			hibernate_enter <= 1'b1;
			cyc(1);
			hibernate_enter <= 1'b0;
			rd_chk(`IPWS_OFF_WAKE_STATUS, 32'h4);
			irq_req[i] <= 1'b1;
			cyc(8);
			chk(32'(core_active), 32'(WAKE_SET[i]));
			irq_req[i] <= 1'b0;
			hard_fault_req <= 1'b1;
			cyc(2);
			chk(32'(irq_valid), 32'h0);
			hard_fault_req <= 1'b0;
			cyc(8);
			chk(32'(core_active), 32'h1);
			wr(`IPWS_OFF_CLR_PENDING, 32'h3fff);
		end
		sleep_enter <= 1'b1;
		cyc(1);
		sleep_enter <= 1'b0;
		rd_chk(`IPWS_OFF_WAKE_STATUS, 32'h2);
		irq_req[4] <= 1'b1;
		cyc(8);
		chk(32'(core_active), 32'h1);
		irq_req[4] <= 1'b0;
		chk(32'(wake_seen), 32'h0000_000f);
		wr(`IPWS_OFF_CLR_PENDING, 32'h3fff);
		// let the stale selection drain so the core model cannot take it
		cyc(2);
		ack_en <= 1'b1;
		wr(`IPWS_OFF_SET_PENDING, 32'h0200);
		cyc(3);
		rd_chk(`IPWS_OFF_ACTIVE, 32'h0000_0200);
		cyc(8);
		ack_en <= 1'b0;
		chk(32'(taken_id), 32'h9);
		rd_chk(`IPWS_OFF_SET_PENDING, 32'h0);
		rd_chk(`IPWS_OFF_ACTIVE, 32'h0);
		// watchdog expiry is wired to a device reset, not left to its interrupt
		wr(`IPWS_OFF_PRIO_BASE, 32'he0e0_e0e0);
		irq_req[3] <= 1'b1;
		cyc(8);
		presetn <= 1'b0;
		cyc(2);
		presetn <= 1'b1;
		irq_req[3] <= 1'b0;
		rd_chk(`IPWS_OFF_PRIO_BASE, 32'h0);
		rd_chk(`IPWS_OFF_SET_PENDING, 32'h0);
		report_and_stop();
	end

endmodule : tb
